/* File: common/dpbi_regs.vh */
// Constants and timing counts for the precharge and burst interrupt block
// Contract
// - Interruption may target any of the four banks; device accepts it.
// - Precharge decodes with select, row strobe, write enable low, column high.
// - Address bit 10 high closes all banks; low closes bank chosen.
// - Read or write samples bit 10; high arms automatic precharge.
// - Read auto-precharge starts AL plus BL/2 later, held for row-active, read-precharge.
// - Auto-precharge starts no sooner than two clocks after last prefetch.
// - Write auto-precharge waits until last write data is stored.
// - Row lockout delays any precharge until array restore completes.
`ifndef DPBI_REGS_VH
`define DPBI_REGS_VH
`define DPBI_CLK_MHZ 50
`define DPBI_NUM_BANKS 4
`define DPBI_BANK_W 2
`define DPBI_TIMER_W 8
`define DPBI_TRAS_NS 40
`define DPBI_TRTP_NS 8
`define DPBI_TRP_NS 15
// Least times round up to cycles
`define DPBI_NS_TO_CYC(ns) (((ns) * `DPBI_CLK_MHZ + 999) / 1000)
`define DPBI_TRAS_CYC `DPBI_NS_TO_CYC(`DPBI_TRAS_NS)
`define DPBI_TRTP_CYC `DPBI_NS_TO_CYC(`DPBI_TRTP_NS)
`define DPBI_TRP_CYC `DPBI_NS_TO_CYC(`DPBI_TRP_NS)
`define DPBI_PREFETCH_GAP 2
`define DPBI_BL4 1'b0
`define DPBI_BL8 1'b1
`define DPBI_CMD_NOP 3'h7
`define DPBI_CMD_ACT 3'h3
`define DPBI_CMD_RD 3'h5
`define DPBI_CMD_WR 3'h4
`define DPBI_CMD_PRE 3'h2
`endif

/* File: rtl/dpbi_bank.v */
// One bank: open state, row lockout and auto-precharge timer
`timescale 1ns/1ps
`include "dpbi_regs.vh"
module dpbi_bank #(
   parameter TRAS_CYC = `DPBI_TRAS_CYC,
   parameter TRP_CYC = `DPBI_TRP_CYC,
   parameter TW = `DPBI_TIMER_W
) (
   input wire core_clk,
   input wire rst_n,
   input wire act,
   input wire pre_req,
   input wire ap_arm,
   input wire [TW-1:0] ap_delay,
   output reg open_ff,
   output reg precharging_ff
);
   reg [TW-1:0] ras_cnt_ff;
   reg [TW-1:0] ap_cnt_ff;
   reg [TW-1:0] rp_cnt_ff;
   reg ap_pend_ff;
   reg pre_pend_ff;
   wire ras_ok = (ras_cnt_ff == {TW{1'b0}});
   wire ap_due = ap_pend_ff && (ap_cnt_ff == {TW{1'b0}});
   // Any close waits for row restore
   wire do_close = open_ff && ras_ok && (pre_pend_ff || pre_req || ap_due);

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         open_ff <= 1'b0;
         precharging_ff <= 1'b0;
         ras_cnt_ff <= {TW{1'b0}};
         ap_cnt_ff <= {TW{1'b0}};
         rp_cnt_ff <= {TW{1'b0}};
         ap_pend_ff <= 1'b0;
         pre_pend_ff <= 1'b0;
      end else begin
         if (ras_cnt_ff != {TW{1'b0}})
            ras_cnt_ff <= ras_cnt_ff - 1'b1;
         if (ap_cnt_ff != {TW{1'b0}})
            ap_cnt_ff <= ap_cnt_ff - 1'b1;
         if (rp_cnt_ff != {TW{1'b0}})
            rp_cnt_ff <= rp_cnt_ff - 1'b1;
         else
            precharging_ff <= 1'b0;
         if (act && !open_ff) begin
            open_ff <= 1'b1;
            ras_cnt_ff <= TRAS_CYC[TW-1:0];
         end
         if (ap_arm) begin
            ap_pend_ff <= 1'b1;
            // Count reaches zero one edge before the edge that starts the precharge
            ap_cnt_ff <= ap_delay - 1'b1;
         end
         if (pre_req && open_ff && !ras_ok)
            pre_pend_ff <= 1'b1;
         if (do_close) begin
            open_ff <= 1'b0;
            ap_pend_ff <= 1'b0;
            pre_pend_ff <= 1'b0;
            precharging_ff <= 1'b1;
            rp_cnt_ff <= TRP_CYC[TW-1:0];
         end
      end
   end
endmodule // dpbi_bank

/* File: rtl/dpbi_top.v */
// Command decode, burst tracking and precharge control for four banks
`timescale 1ns/1ps
`include "dpbi_regs.vh"
module dpbi_top #(
   parameter AL = 0,
   parameter WL = 2,
   parameter WR_CYC = 3,
   parameter TRTP_CYC = `DPBI_TRTP_CYC,
   parameter TRAS_CYC = `DPBI_TRAS_CYC,
   parameter TRP_CYC = `DPBI_TRP_CYC
) (
   core_clk,
   rstn,
   cs_n,
   ras_n,
   cas_n,
   we_n,
   addr10,
   bank_addr,
   burst_len8,
   bank_open,
   bank_precharging,
   burst_active,
   burst_interrupted
);
   input wire core_clk;
   input wire rstn;
   input wire cs_n;
   input wire ras_n;
   input wire cas_n;
   input wire we_n;
   input wire addr10;
   input wire [`DPBI_BANK_W-1:0] bank_addr;
   input wire burst_len8;
   output reg [`DPBI_NUM_BANKS-1:0] bank_open;
   output reg [`DPBI_NUM_BANKS-1:0] bank_precharging;
   output reg burst_active;
   output reg burst_interrupted;

   localparam TW = `DPBI_TIMER_W;

   //--------------------------------------------------------------
   // Reset release
   //--------------------------------------------------------------
   reg rst_meta_ff;
   reg rst_sync_ff;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   //--------------------------------------------------------------
   // Command decode
   //--------------------------------------------------------------
   function [2:0] dpbi_cmd;
      input c, r, a, w;
      begin
         if (c)
            dpbi_cmd = `DPBI_CMD_NOP;
         else
            dpbi_cmd = {r, a, w};
      end
   endfunction

   wire [2:0] cmd = dpbi_cmd(cs_n, ras_n, cas_n, we_n);
   wire is_act = (cmd == `DPBI_CMD_ACT);
   wire is_rd = (cmd == `DPBI_CMD_RD);
   wire is_wr = (cmd == `DPBI_CMD_WR);
   wire is_pre = (cmd == `DPBI_CMD_PRE);

   //--------------------------------------------------------------
   // Burst tracking; spacing counted from programmed length
   //--------------------------------------------------------------
   reg [2:0] burst_cnt_ff;
   reg burst_wr_ff;
   wire [2:0] half_bl = burst_len8 ? 3'h4 : 3'h2;
   // Interrupt seen: same direction, two clocks in, length 8, any bank
   wire intr = burst_active && burst_len8 && (burst_cnt_ff == 3'h2)
      && ((is_rd && !burst_wr_ff) || (is_wr && burst_wr_ff));

   always @(posedge core_clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         burst_cnt_ff <= 3'h0;
         burst_wr_ff <= 1'b0;
         burst_active <= 1'b0;
         burst_interrupted <= 1'b0;
      end else begin
         if (is_rd || is_wr) begin
            burst_cnt_ff <= 3'h1;
            burst_wr_ff <= is_wr;
            burst_active <= 1'b1;
            burst_interrupted <= intr;
         end else if (burst_active) begin
            if (burst_cnt_ff == half_bl)
               burst_active <= 1'b0;
            else
               burst_cnt_ff <= burst_cnt_ff + 3'h1;
         end
      end
   end

   //--------------------------------------------------------------
   // Auto-precharge delay per command kind
   //--------------------------------------------------------------
   wire [TW-1:0] half_bl_w = {{(TW-3){1'b0}}, half_bl};
   wire [TW-1:0] rd_base = AL[TW-1:0] + half_bl_w;
   // Read: last prefetch plus gap and tRTP floor
   localparam [TW-1:0] PF_GAP = `DPBI_PREFETCH_GAP;
   wire [TW-1:0] rd_pf = AL[TW-1:0] + half_bl_w - 8'h02 + PF_GAP;
   wire [TW-1:0] rd_rtp = AL[TW-1:0] + half_bl_w - 8'h02 + TRTP_CYC[TW-1:0];
   wire [TW-1:0] rd_m1 = (rd_base > rd_pf) ? rd_base : rd_pf;
   wire [TW-1:0] rd_dly = (rd_m1 > rd_rtp) ? rd_m1 : rd_rtp;
   // Write: data stored after full burst plus recovery
   wire [TW-1:0] wr_dly = WL[TW-1:0] + half_bl_w + WR_CYC[TW-1:0];
   wire [TW-1:0] ap_delay = is_wr ? wr_dly : rd_dly;

   //--------------------------------------------------------------
   // Four banks
   //--------------------------------------------------------------
   wire [`DPBI_NUM_BANKS-1:0] open_w;
   wire [`DPBI_NUM_BANKS-1:0] prech_w;
   genvar gi;
   generate
      for (gi = 0; gi < `DPBI_NUM_BANKS; gi = gi + 1) begin : g_bank
         wire sel = (bank_addr == gi);
         wire pre_this = is_pre && (addr10 || sel);
         wire arm = (is_rd || is_wr) && addr10 && sel;
         dpbi_bank #(
            .TRAS_CYC(TRAS_CYC),
            .TRP_CYC(TRP_CYC),
            .TW(TW)
         ) u_bank (
            .core_clk(core_clk),
            .rst_n(rst_sync_ff),
            .act(is_act && sel),
            .pre_req(pre_this),
            .ap_arm(arm),
            .ap_delay(ap_delay),
            .open_ff(open_w[gi]),
            .precharging_ff(prech_w[gi])
         );
      end
   endgenerate

   always @(posedge core_clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         bank_open <= 4'h0;
         bank_precharging <= 4'h0;
      end else begin
         bank_open <= open_w;
         bank_precharging <= prech_w;
      end
   end
endmodule // dpbi_top

/* File: bench/dpbi_top_asserts.sv */
// Port checker for the precharge and burst interrupt block
`timescale 1ns/1ps
module dpbi_top_asserts (
   input wire core_clk,
   input wire rstn,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire addr10,
   input wire [1:0] bank_addr,
   input wire burst_len8,
   input wire [3:0] bank_open,
   input wire [3:0] bank_precharging,
   input wire burst_active,
   input wire burst_interrupted
);
   wire act = !cs_n && !ras_n && cas_n && we_n;
   wire pre = !cs_n && !ras_n && cas_n && !we_n;
   wire col = !cs_n && ras_n && !cas_n;
   reg [1:0] pb_ff;
   reg [1:0] cb_ff;
   always @(posedge core_clk) begin
      if (pre) pb_ff <= bank_addr;
      if (col) cb_ff <= bank_addr;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   AST_ACT_DECODE: assert property ((act && bank_addr == 2'd1) |-> ##[2:3] bank_open[1])
      else $error("activate left bank one closed");
   AST_PRE_ALL: assert property ((pre && addr10) |-> ##[1:8] bank_open == 4'h0)
      else $error("all-bank precharge left a bank open");
   AST_PRE_ONE: assert property ((pre && !addr10) |-> ##[1:8] !bank_open[pb_ff])
      else $error("single precharge left its bank open");
   AST_PRE_KEEP: assert property ((pre && !addr10) |=>
      ((~bank_open & $past(bank_open) & ~(4'h1 << pb_ff)) == 4'h0) [*6])
      else $error("single precharge closed another bank");
   AST_RD_AP: assert property ((col && we_n && addr10 && burst_len8 && bank_open[bank_addr])
      |=> bank_open[cb_ff] [*4] ##[1:6] !bank_open[cb_ff])
      else $error("read auto-precharge closed at the wrong time");
   AST_WR_AP: assert property ((col && !we_n && addr10 && burst_len8 && bank_open[bank_addr])
      |=> bank_open[cb_ff] [*8] ##[1:6] !bank_open[cb_ff])
      else $error("write auto-precharge closed at the wrong time");
   AST_INTR: assert property ((col && burst_len8 && $past(col, 2) && $past(we_n, 2) == we_n
      && !$past(addr10, 2) && $past(burst_len8, 2)) |-> ##[1:2] burst_interrupted)
      else $error("interrupt not flagged");
   AST_NO_INTR: assert property ((col && !burst_len8) |-> ##2 (burst_active && !burst_interrupted))
      else $error("short burst flagged or idle");
   AST_LOCKOUT: assert property ((act ##2 (pre && !addr10)) |-> ##2 bank_open[pb_ff] ##[1:6] bank_precharging[pb_ff])
      else $error("held precharge never ran");
endmodule // dpbi_top_asserts
bind dpbi_top dpbi_top_asserts i_chk (.core_clk(core_clk), .rstn(rstn), .cs_n(cs_n),
   .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr10(addr10), .bank_addr(bank_addr),
   .burst_len8(burst_len8), .bank_open(bank_open), .bank_precharging(bank_precharging),
   .burst_active(burst_active), .burst_interrupted(burst_interrupted));

/* File: bench/dpbi_ctrl_model.sv */
// Controller model driving commands; activates wait after a precharge to any bank
`timescale 1ns/1ps
`include "dpbi_regs.vh"
module dpbi_ctrl_model (
   input wire core_clk,
   output reg cs_n,
   output reg ras_n,
   output reg cas_n,
   output reg we_n,
   output reg addr10,
   output reg [1:0] bank_addr
);
   integer cyc = 0;
   integer free_at [0:3];
   integer i;
   initial begin
      for (i = 0; i < 4; i = i + 1) free_at[i] = 0;
      {cs_n, ras_n, cas_n, we_n, addr10, bank_addr} = 7'h7f;
   end
   always @(posedge core_clk) cyc <= cyc + 1;
   // Back-to-back calls land two clocks apart
   task issue(input [2:0] code, input [1:0] bank, input a10);
      begin
         while (code == `DPBI_CMD_ACT && cyc < free_at[bank]) @(negedge core_clk);
         @(negedge core_clk);
         {cs_n, ras_n, cas_n, we_n, addr10, bank_addr} = {1'b0, code, a10, bank};
         if (code == `DPBI_CMD_PRE || (code != `DPBI_CMD_ACT && a10))
            for (i = 0; i < 4; i = i + 1) free_at[i] = cyc + 16;
         @(negedge core_clk);
         cs_n = 1'b1;
         {ras_n, cas_n, we_n, addr10, bank_addr} = ~{ras_n, cas_n, we_n, addr10, bank_addr};
      end
   endtask
endmodule // dpbi_ctrl_model

/* File: bench/tb_top.sv */
// Self-checking bench for the precharge and burst interrupt block
`timescale 1ns/1ps
`include "dpbi_regs.vh"
module tb_top;
   reg core_clk = 1'b0;
   reg rstn = 1'b0;
   reg burst_len8 = 1'b0;
   reg [2:0] kind;
   wire cs_n, ras_n, cas_n, we_n, addr10, burst_active, burst_interrupted;
   wire [1:0] bank_addr;
   wire [3:0] bank_open;
   wire [3:0] bank_precharging;
   integer mismatches = 0;
   integer n_tests = 0;
   integer cycles = 0;
   integer seed = 32'h3df674bb;
   integer exp_open = 0;
   integer k, b, c;
   always #10 core_clk = ~core_clk;
   dpbi_top i_dut (.core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .addr10(addr10), .bank_addr(bank_addr),
      .burst_len8(burst_len8), .bank_open(bank_open), .bank_precharging(bank_precharging),
      .burst_active(burst_active), .burst_interrupted(burst_interrupted));
   dpbi_ctrl_model i_ctrl (.core_clk(core_clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .addr10(addr10), .bank_addr(bank_addr));
   task check(input string name, input [3:0] exp, input [3:0] got);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task settle;
      begin
         repeat (20) @(negedge core_clk);
         check("bank_open", exp_open[3:0], bank_open);
         check("bank_precharging", 4'h0, bank_precharging);
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches = mismatches + 1;
         test_done;
      end
   end
   initial begin
      repeat (16) @(negedge core_clk);
      rstn = 1'b1;
      repeat (3) @(negedge core_clk);
      for (b = 0; b < 4; b = b + 1) i_ctrl.issue(`DPBI_CMD_ACT, b[1:0], 1'b0);
      exp_open = 15;
      settle;
      i_ctrl.issue(`DPBI_CMD_PRE, 2'd2, 1'b0);
      exp_open = 11;
      settle;
      i_ctrl.issue(`DPBI_CMD_PRE, 2'd1, 1'b1);
      exp_open = 0;
      settle;
      // Precharge too soon after activate is held back
      i_ctrl.issue(`DPBI_CMD_ACT, 2'd3, 1'b0);
      i_ctrl.issue(`DPBI_CMD_PRE, 2'd3, 1'b0);
      @(negedge core_clk);
      check("bank_open", 4'h8, bank_open);
      @(negedge core_clk);
      check("bank_precharging", 4'h8, bank_precharging);
      settle;
      for (k = 0; k < 12; k = k + 1) begin
         b = $random(seed) & 3;
         c = (b + 1 + ($random(seed) & 1)) & 3;
         burst_len8 = $random(seed);
         kind = ($random(seed) & 1) ? `DPBI_CMD_RD : `DPBI_CMD_WR;
         i_ctrl.issue(`DPBI_CMD_ACT, b[1:0], 1'b0);
         i_ctrl.issue(`DPBI_CMD_ACT, c[1:0], 1'b0);
         repeat (4) @(negedge core_clk);
         i_ctrl.issue(kind, b[1:0], 1'b0);
         i_ctrl.issue(kind, c[1:0], 1'b1);
         @(negedge core_clk);
         check("burst_interrupted", {3'h0, burst_len8}, {3'h0, burst_interrupted});
         check("burst_active", 4'h1, {3'h0, burst_active});
         exp_open = 1 << b;
         settle;
         i_ctrl.issue(`DPBI_CMD_PRE, b[1:0], 1'b0);
         exp_open = 0;
         settle;
      end
      test_done;
   end
endmodule // tb_top
